// ---- logic/fp_pkg.sv ----
// constants, types and helpers for the frequency protection block
// Operation
// - frequency is timed between two successive rising zero crossings of the voltage
// - voltage source is line channel, busbar channel or a weighted phase sum
// - a new frequency is accepted only after four identical period measurements
// - four invalid measurements in a row force the reported frequency to zero
// - a measurement is valid only while voltage magnitude exceeds 30% of rated
// - under-frequency start needs at least five values below its pickup
// - over-frequency start needs at least five values above its pickup
// - each function has an on/off selection, default on; off gives no outputs
// - start-only option suppresses trip; default off gives start then trip
// - trip follows start after an operate delay in 1 ms steps, default 200 ms
// - pickup in 0.01 Hz steps, default 51 Hz over and 49 Hz under
// - rate of change uses present frequency minus frequency three cycles earlier
// - rate function starts when the rate exceeds its pickup, default 0.5 Hz/s
package fp_pkg;
    localparam int     CLK_PERIOD_NS = 10;
    localparam int     MS_NS         = 1_000_000;
    localparam int     CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint CLK_HZ        = 64'd1_000_000_000 / CLK_PERIOD_NS;
    localparam longint FREQ_NUM      = CLK_HZ * 100;
    localparam int     CONFIRM_N     = 4;
    localparam int     INVALID_N     = 4;
    localparam int     START_N       = 5;
    localparam int     RATE_LAG      = 3;
    localparam int     VMIN_PCT      = 30;
    localparam int     RATE_SCALE    = RATE_LAG * 100;
    localparam int     NW            = 34;
    localparam int     PW            = 24;
    localparam int     FW            = 16;
    localparam int     AW            = 4;
    localparam int     DW            = 32;
    localparam logic [PW-1:0] PER_MAX = 24'hff_ffff;
    // register offsets
    localparam logic [AW-1:0] REG_CTRL       = 4'h0;
    localparam logic [AW-1:0] REG_OVER_PICK  = 4'h1;
    localparam logic [AW-1:0] REG_UNDER_PICK = 4'h2;
    localparam logic [AW-1:0] REG_RATE_PICK  = 4'h3;
    localparam logic [AW-1:0] REG_OVER_DLY   = 4'h4;
    localparam logic [AW-1:0] REG_UNDER_DLY  = 4'h5;
    localparam logic [AW-1:0] REG_RATE_DLY   = 4'h6;
    localparam logic [AW-1:0] REG_RATED      = 4'h7;
    localparam logic [AW-1:0] REG_STATUS     = 4'h8;
    localparam logic [AW-1:0] REG_FREQ       = 4'h9;
    localparam logic [AW-1:0] REG_RATE       = 4'ha;
    // control fields
    localparam int CTL_OVER_EN  = 0;
    localparam int CTL_OVER_SO  = 1;
    localparam int CTL_UNDER_EN = 2;
    localparam int CTL_UNDER_SO = 3;
    localparam int CTL_RATE_EN  = 4;
    localparam int CTL_RATE_SO  = 5;
    localparam int CTL_SRC      = 6;
    // reset values
    localparam logic [7:0]    CTRL_RST       = 8'h15;
    localparam logic [FW-1:0] OVER_PICK_RST  = 16'h13ec;
    localparam logic [FW-1:0] UNDER_PICK_RST = 16'h1324;
    localparam logic [FW-1:0] RATE_PICK_RST  = 16'h0032;
    localparam logic [15:0]   DELAY_RST      = 16'h00c8;
    localparam logic [15:0]   RATED_RST      = 16'h4000;

    typedef enum logic [1:0] {SRC_LINE = 2'b00, SRC_BUS = 2'b01, SRC_SUM = 2'b10} fp_src_t;

    typedef struct packed {
        logic signed [15:0] line;
        logic signed [15:0] bus;
        logic signed [15:0] ph1;
        logic signed [15:0] ph2;
        logic signed [15:0] ph3;
    } fp_sample_t;

    typedef struct packed {
        logic over_start;
        logic over_trip;
        logic under_start;
        logic under_trip;
        logic rate_start;
        logic rate_trip;
    } fp_flags_t;

    function automatic logic signed [17:0] fp_sext(input logic signed [15:0] x);
        return {{2{x[15]}}, x};
    endfunction

    function automatic logic [17:0] fp_abs(input logic signed [17:0] x);
        return x[17] ? 18'(-x) : 18'(x);
    endfunction
endpackage

// ---- logic/fp_div.sv ----
// iterative divider turning a period count into a saturated frequency
`timescale 1ns/1ns
module fp_div #(
    parameter int NUMW = 34,
    parameter int DENW = 24,
    parameter int QW   = 16
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            go,
    input  wire logic [NUMW-1:0] num,
    input  wire logic [DENW-1:0] den,
    output logic                 idle,
    output logic                 done,
    output logic [QW-1:0]        quo
);
    typedef enum logic [1:0] {DV_IDLE = 2'b00, DV_RUN = 2'b01, DV_DONE = 2'b11} fp_div_st_t;

    if (QW > NUMW || DENW < 2) begin : g_chk
        $error("fp_div: unsupported widths");
    end

    fp_div_st_t                st;
    fp_div_st_t                next_st;
    logic [NUMW-1:0]           q;
    logic [DENW:0]             r;
    logic [DENW-1:0]           den_q;
    logic [$clog2(NUMW+1)-1:0] n;

    wire logic [DENW:0]   shifted = {r[DENW-1:0], q[NUMW-1]};
    wire logic [DENW+1:0] diff    = {1'b0, shifted} - {2'b00, den_q};
    wire logic            fits    = !diff[DENW+1];

    assign idle = st == DV_IDLE;
    assign done = st == DV_DONE;
    assign quo  = |q[NUMW-1:QW] ? {QW{1'b1}} : q[QW-1:0];

    always_comb begin
        case (st)
            DV_IDLE: next_st = go ? DV_RUN : DV_IDLE;
            DV_RUN:  next_st = (n == 1) ? DV_DONE : DV_RUN;
            DV_DONE: next_st = DV_IDLE;
            default: next_st = DV_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st    <= DV_IDLE;
            q     <= '0;
            r     <= '0;
            den_q <= '0;
            n     <= '0;
        end else begin
            st <= next_st;
            if (st == DV_IDLE && go) begin
                q     <= num;
                r     <= '0;
                den_q <= den;
                n     <= ($clog2(NUMW+1))'(NUMW);
            end else if (st == DV_RUN) begin
                q <= {q[NUMW-2:0], fits};
                r <= fits ? diff[DENW:0] : shifted;
                n <= n - 1'b1;
            end
        end
    end
endmodule

// ---- logic/fp_stage.sv ----
// one protection stage: start counting, operate delay and trip
`timescale 1ns/1ns
module fp_stage #(
    parameter int NEED     = 5,
    parameter int PRESCALE = 100000
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        enable,
    input  wire logic        start_only,
    input  wire logic        meas,
    input  wire logic        hit,
    input  wire logic [15:0] delay_ms,
    output logic             start,
    output logic             trip
);
    localparam int CW = $clog2(NEED + 1);
    localparam int PSW = $clog2(PRESCALE);

    if (NEED < 1 || PRESCALE < 2) begin : g_chk
        $error("fp_stage: unsupported parameters");
    end

    logic [CW-1:0]  hits;
    logic [PSW-1:0] pre;
    logic [15:0]    ms;

    wire logic [CW-1:0] next_hits = !enable ? '0
                                  : !meas ? hits
                                  : !hit ? '0
                                  : (hits == CW'(NEED)) ? hits : hits + 1'b1;
    wire logic next_start = enable && next_hits == CW'(NEED);
    wire logic ms_tick    = pre == PSW'(PRESCALE - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hits  <= '0;
            start <= 1'b0;
            trip  <= 1'b0;
            pre   <= '0;
            ms    <= '0;
        end else begin
            hits  <= next_hits;
            start <= next_start;
            trip  <= enable && start && !start_only && ms >= delay_ms;
            if (!start) begin
                pre <= '0;
                ms  <= '0;
            end else begin
                pre <= ms_tick ? '0 : pre + 1'b1;
                if (ms_tick && ms != 16'hffff) begin
                    ms <= ms + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [31:0] held;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= '0;
        end else begin
            held <= start ? held + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_off_silent: assert property (!enable |=> !start && !trip)
        else $error("stage active while off");
    a_start_only: assert property (start_only |=> !trip)
        else $error("trip while start only");
    a_trip_hold: assert property ($rose(trip) |-> held >= 32'(delay_ms) * 32'(PRESCALE))
        else $error("trip before delay elapsed");
    a_trip_start: assert property (trip |-> $past(start) && $past(ms >= delay_ms))
        else $error("trip without held start");
endmodule

// ---- logic/fp_top.sv ----
// frequency protection: period measurement, confirmation and three stages
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module fp_top import fp_pkg::*; #(
    parameter int PRESCALE = CYC_PER_MS
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          smp_valid,
    input  wire fp_sample_t    smp,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [DW-1:0]      reg_rdata,
    output wire fp_flags_t     flags,
    output logic               freq_valid,
    output logic [FW-1:0]      freq_value
);
    if (PRESCALE < 2) begin : g_chk
        $error("fp_top: prescale too small");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]    ctrl;
    logic [FW-1:0] over_pick;
    logic [FW-1:0] under_pick;
    logic [FW-1:0] rate_pick;
    logic [15:0]   over_dly;
    logic [15:0]   under_dly;
    logic [15:0]   rate_dly;
    logic [15:0]   rated;
    logic [16:0]   rate_df;

    wire logic wr_ctrl  = reg_wr && reg_addr == REG_CTRL;
    wire logic wr_opk   = reg_wr && reg_addr == REG_OVER_PICK;
    wire logic wr_upk   = reg_wr && reg_addr == REG_UNDER_PICK;
    wire logic wr_rpk   = reg_wr && reg_addr == REG_RATE_PICK;
    wire logic wr_odl   = reg_wr && reg_addr == REG_OVER_DLY;
    wire logic wr_udl   = reg_wr && reg_addr == REG_UNDER_DLY;
    wire logic wr_rdl   = reg_wr && reg_addr == REG_RATE_DLY;
    wire logic wr_rated = reg_wr && reg_addr == REG_RATED;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl       <= CTRL_RST;
            over_pick  <= OVER_PICK_RST;
            under_pick <= UNDER_PICK_RST;
            rate_pick  <= RATE_PICK_RST;
            over_dly   <= DELAY_RST;
            under_dly  <= DELAY_RST;
            rate_dly   <= DELAY_RST;
            rated      <= RATED_RST;
        end else begin
            if (wr_ctrl)  ctrl       <= reg_wdata[7:0];
            if (wr_opk)   over_pick  <= reg_wdata[FW-1:0];
            if (wr_upk)   under_pick <= reg_wdata[FW-1:0];
            if (wr_rpk)   rate_pick  <= reg_wdata[FW-1:0];
            if (wr_odl)   over_dly   <= reg_wdata[15:0];
            if (wr_udl)   under_dly  <= reg_wdata[15:0];
            if (wr_rdl)   rate_dly   <= reg_wdata[15:0];
            if (wr_rated) rated      <= reg_wdata[15:0];
        end
    end

    wire logic [DW-1:0] status = {26'h000_0000, flags.over_trip, flags.under_trip,
                                  flags.rate_trip, flags.over_start,
                                  flags.under_start, flags.rate_start} << 1
                                 | {31'h0000_0000, freq_valid};

    wire logic [DW-1:0] rd_mux =
          (reg_addr == REG_CTRL)       ? {24'h00_0000, ctrl}
        : (reg_addr == REG_OVER_PICK)  ? {16'h0000, over_pick}
        : (reg_addr == REG_UNDER_PICK) ? {16'h0000, under_pick}
        : (reg_addr == REG_RATE_PICK)  ? {16'h0000, rate_pick}
        : (reg_addr == REG_OVER_DLY)   ? {16'h0000, over_dly}
        : (reg_addr == REG_UNDER_DLY)  ? {16'h0000, under_dly}
        : (reg_addr == REG_RATE_DLY)   ? {16'h0000, rate_dly}
        : (reg_addr == REG_RATED)      ? {16'h0000, rated}
        : (reg_addr == REG_STATUS)     ? status
        : (reg_addr == REG_FREQ)       ? {16'h0000, freq_value}
        : (reg_addr == REG_RATE)       ? {{15{rate_df[16]}}, rate_df}
        : 32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // ------------------------------------------------------------
    // source selection and zero crossing
    // ------------------------------------------------------------
    fp_src_t src;
    assign src = fp_src_t'(ctrl[CTL_SRC +: 2]);

    // weighted phase sum: ph1 minus half of ph2 and ph3, 1.5 x ph1 when balanced
    wire logic signed [17:0] v_half = (fp_sext(smp.ph2) + fp_sext(smp.ph3)) >>> 1;
    wire logic signed [17:0] v_sum  = fp_sext(smp.ph1) - v_half;
    wire logic signed [17:0] v_sel  = (src == SRC_BUS) ? fp_sext(smp.bus)
                                    : (src == SRC_SUM) ? v_sum
                                    : fp_sext(smp.line);
    wire logic [17:0] v_mag = fp_abs(v_sel);

    logic          v_neg;
    logic          armed;
    logic [PW-1:0] per;
    logic [17:0]   peak;

    wire logic xing    = smp_valid && v_neg && !v_sel[17];
    wire logic per_ovf = per == PER_MAX;
    wire logic mag_ok  = (32'(peak) * 32'd100) > (32'(rated) * 32'(VMIN_PCT));
    wire logic div_idle;
    wire logic div_go  = xing && armed && mag_ok && div_idle;
    wire logic inv_evt = (xing && armed && !mag_ok) || per_ovf;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            v_neg <= 1'b0;
            armed <= 1'b0;
            per   <= '0;
            peak  <= '0;
        end else begin
            if (smp_valid) v_neg <= v_sel[17];
            per <= (xing || per_ovf) ? PW'(1) : per + 1'b1;
            if (xing || per_ovf) begin
                armed <= xing;
                peak  <= '0;
            end else if (smp_valid && v_mag > peak) begin
                peak <= v_mag;
            end
        end
    end

    wire logic          div_done;
    wire logic [FW-1:0] quo;

    fp_div #(
        .NUMW (NW),
        .DENW (PW),
        .QW   (FW)
    ) u_div (
        .clk  (clk),
        .rst  (rst),
        .go   (div_go),
        .num  (FREQ_NUM[NW-1:0]),
        .den  (per),
        .idle (div_idle),
        .done (div_done),
        .quo  (quo)
    );

    // ------------------------------------------------------------
    // confirmation of measured frequency
    // ------------------------------------------------------------
    logic [FW-1:0] last_raw;
    logic [2:0]    same_cnt;
    logic [2:0]    inv_cnt;
    logic          meas;

    wire logic [2:0] next_same = (quo != last_raw) ? 3'd1
                               : (same_cnt == 3'(CONFIRM_N)) ? same_cnt
                               : same_cnt + 3'd1;
    wire logic confirm_now = div_done && next_same == 3'(CONFIRM_N);
    wire logic zero_now    = inv_evt && !div_done && inv_cnt == 3'(INVALID_N - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_raw   <= '0;
            same_cnt   <= '0;
            inv_cnt    <= '0;
            freq_value <= '0;
            freq_valid <= 1'b0;
            meas       <= 1'b0;
        end else begin
            meas <= div_done;
            if (div_done) begin
                last_raw <= quo;
                same_cnt <= next_same;
                inv_cnt  <= '0;
                if (confirm_now) begin
                    freq_value <= quo;
                    freq_valid <= 1'b1;
                end
            end else if (inv_evt) begin
                same_cnt <= '0;
                if (inv_cnt != 3'(INVALID_N)) inv_cnt <= inv_cnt + 3'd1;
                if (zero_now) begin
                    freq_value <= '0;
                    freq_valid <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // rate of change over three measured cycles
    // ------------------------------------------------------------
    logic [FW-1:0] hist [RATE_LAG];
    logic [1:0]    hist_n;

    wire logic signed [16:0] df   = $signed({1'b0, freq_value}) - $signed({1'b0, hist[RATE_LAG-1]});
    wire logic signed [33:0] prod = 34'(df) * 34'($signed({1'b0, freq_value}));
    wire logic signed [33:0] thr  = 34'($signed(rate_pick)) * 34'(RATE_SCALE);
    wire logic rate_full = hist_n == 2'(RATE_LAG);
    wire logic rate_hit  = freq_valid && rate_full
                         && (rate_pick[FW-1] ? prod < thr : prod > thr);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hist_n  <= '0;
            rate_df <= '0;
            for (int i = 0; i < RATE_LAG; i++) hist[i] <= '0;
        end else if (meas) begin
            if (!freq_valid) begin
                hist_n <= '0;
            end else begin
                hist[0] <= freq_value;
                for (int i = 1; i < RATE_LAG; i++) hist[i] <= hist[i-1];
                if (!rate_full) hist_n <= hist_n + 2'd1;
                if (rate_full) rate_df <= df;
            end
        end
    end

    // ------------------------------------------------------------
    // protection stages
    // ------------------------------------------------------------
    wire logic over_hit  = freq_valid && freq_value > over_pick;
    wire logic under_hit = freq_valid && freq_value < under_pick;

    fp_stage #(.NEED(START_N), .PRESCALE(PRESCALE)) u_over (
        .clk        (clk),
        .rst        (rst),
        .enable     (ctrl[CTL_OVER_EN]),
        .start_only (ctrl[CTL_OVER_SO]),
        .meas       (meas),
        .hit        (over_hit),
        .delay_ms   (over_dly),
        .start      (flags.over_start),
        .trip       (flags.over_trip)
    );

    fp_stage #(.NEED(START_N), .PRESCALE(PRESCALE)) u_under (
        .clk        (clk),
        .rst        (rst),
        .enable     (ctrl[CTL_UNDER_EN]),
        .start_only (ctrl[CTL_UNDER_SO]),
        .meas       (meas),
        .hit        (under_hit),
        .delay_ms   (under_dly),
        .start      (flags.under_start),
        .trip       (flags.under_trip)
    );

    fp_stage #(.NEED(1), .PRESCALE(PRESCALE)) u_rate (
        .clk        (clk),
        .rst        (rst),
        .enable     (ctrl[CTL_RATE_EN]),
        .start_only (ctrl[CTL_RATE_SO]),
        .meas       (meas),
        .hit        (rate_hit),
        .delay_ms   (rate_dly),
        .start      (flags.rate_start),
        .trip       (flags.rate_trip)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_confirm_four: assert property (confirm_now |=> freq_valid && freq_value == $past(quo))
        else $error("confirmed value not reported");
    a_value_source: assert property (freq_valid && $changed(freq_value) |-> $past(confirm_now))
        else $error("frequency changed without confirmation");
    a_invalid_zero: assert property (zero_now |=> freq_value == '0 && !freq_valid)
        else $error("frequency not cleared after invalid run");
    a_rate_start: assert property ($rose(flags.rate_start) |-> $past(rate_hit) && $past(meas))
        else $error("rate start without rate hit");
    a_go_busy: assert property (div_go |=> !div_idle)
        else $error("crossing not taken by divider");
    a_zero_value: assert property (!freq_valid |-> freq_value == '0)
        else $error("invalid frequency not zero");
    // start may only rise on a measurement beyond its pickup
    a_over_pick: assert property ($rose(flags.over_start)
        |-> $past(freq_value > over_pick)) else $error("over start below pickup");
    a_under_pick: assert property ($rose(flags.under_start)
        |-> $past(freq_value < under_pick)) else $error("under start above pickup");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside read cycle");

    c_over_trip:  cover property ($rose(flags.over_trip));
    c_under_trip: cover property ($rose(flags.under_trip));
    c_rate_start: cover property ($rose(flags.rate_start));
    c_freq_valid: cover property ($rose(freq_valid));
    c_src_sum:    cover property (div_go && src == SRC_SUM);
endmodule

// ---- verif/fp_src_model.sv ----
// square-wave voltage sample source for the measurement input
`timescale 1ns/1ns
module fp_src_model import fp_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] amp,
    input  wire logic [15:0] half,
    output logic             smp_valid,
    output fp_sample_t       smp
);
    logic               neg;
    logic [15:0]        cnt;
    logic signed [15:0] v;
    logic               flip;
    assign flip = (cnt == half - 16'h0001);
    assign v    = neg ? -$signed(amp) : $signed(amp);
    // one sample a cycle, so the period in cycles is twice half
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
            neg <= 1'b1;
            smp_valid <= 1'b0;
            smp <= '0;
        end else begin
            cnt <= flip ? 16'h0000 : cnt + 16'h0001;
            if (flip) neg <= ~neg;
            smp_valid <= 1'b1;
            smp <= '{line: v, bus: v, ph1: v, ph2: -(v >>> 1), ph3: -(v >>> 1)};
        end
    end
endmodule

// ---- verif/frequency_protection_tb.sv ----
// self-checking bench for the frequency protection block
`timescale 1ns/1ns
module frequency_protection_tb import fp_pkg::*;;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            smp_valid;
    fp_sample_t      smp;
    logic [AW-1:0]   reg_addr = '0;
    logic [DW-1:0]   reg_wdata = '0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [DW-1:0]   reg_rdata;
    fp_flags_t       flags;
    logic            freq_valid;
    logic [FW-1:0]   freq_value;
    logic [15:0]     amp = 16'h0000;
    logic [15:0]     half = 16'h01f4;
    int              fail_count = 0;
    int              samples_checked = 0;
    int              cyc = 0;
    always #5 clk = ~clk;
    fp_top #(.PRESCALE(10)) dut (.clk(clk), .rst(rst), .smp_valid(smp_valid), .smp(smp),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flags(flags), .freq_valid(freq_valid),
        .freq_value(freq_value));
    fp_src_model src (.clk(clk), .rst(rst), .amp(amp), .half(half),
        .smp_valid(smp_valid), .smp(smp));
    task automatic give_verdict;
        $display("compared %0d, mismatched %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic waitp(input int n);
        repeat (n * 1000) @(posedge clk);
        #1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd(REG_CTRL, 32'h0000_0015);
        rd(REG_OVER_PICK, 32'h0000_13ec);
        rd(REG_UNDER_PICK, 32'h0000_1324);
        rd(REG_RATE_PICK, 32'h0000_0032);
        rd(REG_OVER_DLY, 32'h0000_00c8);
        rd(4'hb, 32'h0000_0000);
        wr(REG_OVER_DLY, 32'h0000_0003);
        rd(REG_OVER_DLY, 32'h0000_0003);
        $display("test regs done");
    endtask
    task automatic t_measure;
        int n;
        amp <= 16'h1f40;
        waitp(7);
        chk(freq_valid, 1'b1);
        chk(freq_value, 16'hffff);
        n = 0;
        while (flags.over_start !== 1'b1 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        #1 chk(flags.over_start, 1'b1);
        chk(flags.under_start, 1'b0);
        repeat (25) @(posedge clk);
        #1 chk(flags.over_trip, 1'b0);
        repeat (15) @(posedge clk);
        #1 chk(flags.over_trip, 1'b1);
        chk(flags.rate_start, 1'b0);
        chk(flags.under_trip, 1'b0);
        chk(flags.rate_trip, 1'b0);
        rd(REG_STATUS, 32'h0000_0049);
        rd(REG_RATE, 32'h0000_0000);
        $display("test measure done");
    endtask
    task automatic t_modes;
        wr(REG_CTRL, 32'h0000_0017);
        repeat (3) @(posedge clk);
        #1 chk(flags.over_trip, 1'b0);
        chk(flags.over_start, 1'b1);
        wr(REG_CTRL, 32'h0000_0014);
        repeat (3) @(posedge clk);
        #1 chk(flags.over_start, 1'b0);
        wr(REG_CTRL, 32'h0000_0015);
        $display("test modes done");
    endtask
    task automatic t_invalid;
        amp <= 16'h0bb8;
        waitp(6);
        chk(freq_value, 16'h0000);
        chk(freq_valid, 1'b0);
        rd(REG_FREQ, 32'h0000_0000);
        $display("test invalid done");
    endtask
    task automatic t_source;
        wr(REG_CTRL, 32'h0000_0095);
        amp <= 16'h0fa0;
        rd(REG_CTRL, 32'h0000_0095);
        waitp(6);
        chk(freq_valid, 1'b1);
        chk(freq_value, 16'hffff);
        $display("test source done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_measure();
        t_modes();
        t_invalid();
        t_source();
        give_verdict();
    end
endmodule
